// file: core/relay_time_proportioning_output.v
// Operation
// - mode input picks two-state or duty-cycle drive
// - invert reverses relay polarity against demand
// - default limits: 0% off, 100% on, 50% even
// - demand limits map linearly onto duty limits
// - duty upper limit below full keeps switching
// - duty lower limit above zero keeps pulsing
// - shortest pulse 0.01-150 s, automatic gives 110 ms
// - 50% demand automatic gives 110 ms on and off
// - limits and pulse ignored in two-state mode
// - state flag reads 0 on, 1 off
// - demand 0-100 duty mode, 0-1 two-state mode
`include "relay_tpo_consts.vh"

module relay_time_proportioning_output #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input  wire        sys_clk,
  input  wire        rst_b,
  input  wire        two_state_mode,
  input  wire        invert,
  input  wire [13:0] demand_input,
  input  wire [13:0] demand_upper_limit,
  input  wire [13:0] demand_lower_limit,
  input  wire [13:0] duty_upper_limit,
  input  wire [13:0] duty_lower_limit,
  input  wire [13:0] shortest_pulse_period,
  output reg         relay_energise_q,
  output reg         output_state_q,
  output reg  [13:0] duty_q
);

  localparam ST_OFF = 1'b0;
  localparam ST_ON  = 1'b1;

  // a * b / c with a wide product; c of zero returns a unchanged
  function [31:0] mul_div;
    input [31:0] a;
    input [13:0] b;
    input [13:0] c;
    reg   [45:0] prod;
    reg   [45:0] quot;
    begin
      prod = a * b;
      quot = {14'h0000, a};
      if (c != `ZERO_SCALE) begin
        quot = prod / c;
      end
      // callers keep the quotient below 2**32, so the cut is safe
      mul_div = quot[31:0];
    end
  endfunction

  // distance between two limits; callers guard the reversed case
  function [13:0] span_of;
    input [13:0] hi;
    input [13:0] lo;
    begin
      span_of = hi - lo;
    end
  endfunction

  // pull a value into a window; with a reversed window a value above the upper gets the upper, any other the lower
  function [13:0] clamp_to;
    input [13:0] v;
    input [13:0] hi;
    input [13:0] lo;
    begin
      if (v > hi) begin
        clamp_to = hi;
      end else if (v < lo) begin
        clamp_to = lo;
      end else begin
        clamp_to = v;
      end
    end
  endfunction

  // the shorter of the two phase fractions sets the period
  function [13:0] smaller_of;
    input [13:0] x;
    input [13:0] y;
    begin
      if (x < y) begin
        smaller_of = x;
      end else begin
        smaller_of = y;
      end
    end
  endfunction

  wire        ms_tick;
  reg  [13:0] dem_clamp;
  reg  [13:0] duty_d;
  reg  [13:0] span_in;
  reg  [13:0] span_out;
  reg  [31:0] pulse_ms;
  reg  [13:0] short_frac;
  reg  [31:0] on_ms;
  reg  [31:0] off_ms;
  reg  [31:0] scaled;
  reg         state_q;
  // ticks still to run in the current phase
  reg  [31:0] left_q;
  reg         demand_on;

  ms_timebase #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timebase (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .ms_tick_q (ms_tick)
  );

  // demand scaling, a reversed or flat demand span falls back to a step
  always @* begin
    dem_clamp = clamp_to(demand_input, demand_upper_limit,
                         demand_lower_limit);
    span_in   = span_of(demand_upper_limit, demand_lower_limit);
    span_out  = span_of(duty_upper_limit, duty_lower_limit);
    scaled    = mul_div({18'h00000, span_of(dem_clamp, demand_lower_limit)},
                        span_out, span_in);
    if (demand_upper_limit <= demand_lower_limit) begin
      // flat span: any demand above the lower limit drives the top
      if (demand_input > demand_lower_limit) begin
        duty_d = duty_upper_limit;
      end else begin
        duty_d = duty_lower_limit;
      end
    end else if (duty_upper_limit < duty_lower_limit) begin
      duty_d = duty_lower_limit;
    end else begin
      duty_d = duty_lower_limit + scaled[13:0];
    end
    // limits above full scale are cut so duty never overruns a period
    if (duty_d > `FULL_SCALE) begin
      duty_d = `FULL_SCALE;
    end
  end

  // shorter phase lasts exactly the shortest pulse, the other scales up
  always @* begin
    if (shortest_pulse_period == `PULSE_AUTO_SEL) begin
      pulse_ms = `AUTO_PULSE_MS;
    end else begin
      pulse_ms = {18'h00000, shortest_pulse_period} * `PULSE_UNIT_MS;
    end
    short_frac = smaller_of(duty_q, span_of(`FULL_SCALE, duty_q));
    on_ms      = mul_div(pulse_ms, duty_q, short_frac);
    off_ms     = mul_div(pulse_ms, span_of(`FULL_SCALE, duty_q),
                         short_frac);
  end

  // duty is sampled only at a cycle boundary so a phase never tears
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_OFF;
      left_q  <= 32'h00000000;
      duty_q  <= `ZERO_SCALE;
    end else if (two_state_mode) begin
      // entering two-state drops any phase in flight
      state_q <= ST_OFF;
      left_q  <= 32'h00000000;
      duty_q  <= duty_d;
    end else if (ms_tick) begin
      if (left_q != 32'h00000000) begin
        left_q <= left_q - 32'h00000001;
      end else begin
        case (state_q)
          ST_OFF: begin
            if (duty_q == `ZERO_SCALE) begin
              state_q <= ST_OFF;
              duty_q  <= duty_d;
            end else begin
              state_q <= ST_ON;
              left_q  <= on_ms - 32'h00000001;
            end
          end
          ST_ON: begin
            // held on: duty re-read each tick so a drop is seen
            if (duty_q == `FULL_SCALE) begin
              state_q <= ST_ON;
              duty_q  <= duty_d;
            end else begin
              state_q <= ST_OFF;
              left_q  <= off_ms - 32'h00000001;
              duty_q  <= duty_d;
            end
          end
          default: begin
            // a one-bit state has no other code; parks the machine
            state_q <= ST_OFF;
            left_q  <= 32'h00000000;
          end
        endcase
      end
    end
  end

  // two-state demand is 0 or 1, any non-zero counts as on
  always @* begin
    if (two_state_mode) begin
      demand_on = (demand_input != `ZERO_SCALE);
    end else begin
      demand_on = (state_q == ST_ON);
    end
  end

  // flag mirrors the contact: 0 energised, 1 released, invert included
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      // coil released at reset whatever invert says, a known contact
      relay_energise_q <= 1'b0;
      output_state_q   <= 1'b1;
    end else begin
      relay_energise_q <= demand_on ^ invert;
      output_state_q   <= ~(demand_on ^ invert);
    end
  end

endmodule

// file: shared/relay_tpo_consts.vh
`ifndef RELAY_TPO_CONSTS_VH
`define RELAY_TPO_CONSTS_VH

// demand and limits are in hundredths of a percent
`define FULL_SCALE      14'h2710
`define ZERO_SCALE      14'h0000
`define DEMAND_W        14

// shortest pulse setting counts 10 ms units, zero selects automatic
`define PULSE_UNIT_MS   32'h0000000A
`define AUTO_PULSE_MS   32'h0000006E
`define PULSE_AUTO_SEL  14'h0000

// timebase, both in picoseconds
`define CLK_PERIOD_PS   32'h00000FA0
`define MS_PS           32'h3B9ACA00
`define TICK_CYCLES     (`MS_PS / `CLK_PERIOD_PS)

`define PHASE_OFF       1'b0
`define PHASE_ON        1'b1

`endif

// file: core/ms_timebase.v
`include "relay_tpo_consts.vh"

module ms_timebase #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input  wire sys_clk,
  input  wire rst_b,
  output reg  ms_tick_q
);

  reg [31:0] div_q;

  // free-running, never restarted, so cycle edges keep a steady pace
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q     <= 32'h00000000;
      ms_tick_q <= 1'b0;
    end else if (div_q == TICK_CYCLES - 1) begin
      div_q     <= 32'h00000000;
      ms_tick_q <= 1'b1;
    end else begin
      div_q     <= div_q + 32'h00000001;
      ms_tick_q <= 1'b0;
    end
  end

endmodule

// file: sim/relay_load.sv
// coil model: records the last completed energised and released spans
module relay_load (
  input  wire logic clk,
  input  wire logic coil,
  output int        on_len,
  output int        off_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last;
  int   run;
  always @(posedge clk) begin
    last <= coil;
    if (coil !== last) begin
      if (last) on_len <= run;
      else off_len <= run;
      run <= 1;
    end else run <= run + 1;
  end
endmodule

// file: sim/relay_tpo_props.sv
module relay_tpo_props #(parameter TICK_CYCLES = 4) (
  input wire        sys_clk, rst_b, two_state_mode, invert,
  input wire [13:0] demand_input, demand_upper_limit, demand_lower_limit,
  input wire [13:0] duty_upper_limit, duty_lower_limit,
  input wire [13:0] shortest_pulse_period,
  input wire        relay_energise_q, output_state_q,
  input wire [13:0] duty_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_flag_inverse: assert property (output_state_q == !relay_energise_q)
    else $error("flag not inverse");
  a_two_state: assert property (two_state_mode [*2] |->
    relay_energise_q == ((|$past(demand_input)) ^ $past(invert)))
    else $error("two-state relay wrong");
  a_full_on: assert property
    ((!two_state_mode && !invert && duty_q == 14'h2710 &&
      relay_energise_q) [*2] |=> relay_energise_q)
    else $error("full duty not on");
  a_zero_off: assert property
    ((!two_state_mode && !invert && duty_q == 14'h0000) [*3] |-> !relay_energise_q)
    else $error("zero duty not off");
  a_zero_inverted: assert property
    ((!two_state_mode && invert && duty_q == 14'h0000) [*3] |-> relay_energise_q)
    else $error("inverted zero not energised");
  a_min_on: assert property ($rose(relay_energise_q) && !two_state_mode &&
    !$past(two_state_mode) && !invert |=> relay_energise_q [*7])
    else $error("on pulse too short");
  a_duty_range: assert property (duty_q <= 14'h2710)
    else $error("duty above full");
  a_duty_limits: assert property ($changed(duty_q) && !two_state_mode &&
    !$past(two_state_mode) |-> duty_q >= $past(duty_lower_limit) &&
    duty_q <= $past(duty_upper_limit))
    else $error("duty outside limits");
endmodule
bind relay_time_proportioning_output relay_tpo_props
  #(.TICK_CYCLES(TICK_CYCLES)) props (
  .sys_clk(sys_clk), .rst_b(rst_b), .two_state_mode(two_state_mode),
  .invert(invert), .demand_input(demand_input),
  .demand_upper_limit(demand_upper_limit),
  .demand_lower_limit(demand_lower_limit),
  .duty_upper_limit(duty_upper_limit), .duty_lower_limit(duty_lower_limit),
  .shortest_pulse_period(shortest_pulse_period),
  .relay_energise_q(relay_energise_q), .output_state_q(output_state_q),
  .duty_q(duty_q));

// file: sim/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, rst_b, ts, inv, relay, st;
  logic [13:0] dem, dhi, dlo, olo, ohi, pul, duty;
  int          on_len, off_len, fail_count, cmp_count;
  `define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
    fail_count++; $display("BAD %s exp %0d got %0d", n, e, s); end end
  // tick shortened to 4 clocks, so each ms is 4 cycles
  relay_time_proportioning_output #(.TICK_CYCLES(4)) DUT (.sys_clk(sys_clk),
    .rst_b(rst_b), .two_state_mode(ts), .invert(inv), .demand_input(dem),
    .demand_upper_limit(dhi), .demand_lower_limit(dlo),
    .duty_upper_limit(ohi), .duty_lower_limit(olo),
    .shortest_pulse_period(pul), .relay_energise_q(relay),
    .output_state_q(st), .duty_q(duty));
  relay_load load (.clk(sys_clk), .coil(relay), .on_len(on_len),
    .off_len(off_len));
  task test_done;
    $display("cmp %0d bad %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task set(input logic t, i, input logic [13:0] d, h, l, u, p, input int n);
    @(negedge sys_clk);
    {ts, inv, dem, dhi, olo, ohi, pul} = {t, i, d, h, l, u, p};
    repeat (n) @(negedge sys_clk);
  endtask
  // waits long enough for the new duty to latch and two full periods
  task run(input logic [13:0] d, h, l, u, p, e, input int on, off);
    set(0, 0, d, h, l, u, p, 3000);
    `CHK("duty", e, duty)
    `CHK("on", on, on_len)
    `CHK("off", off, off_len)
    $display("run end %0d", d);
  endtask
  initial begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    #150000;
    fail_count++;
    test_done;
  end
  initial begin
    rst_b = 0;
    {ts, inv, dem, dhi, olo, ohi, pul} = '0;
    dlo = 14'h0000;
    repeat (5) @(negedge sys_clk);
    rst_b = 1;
    for (int i = 0; i < 4; i++) begin
      set(1, i[1], {13'h0, i[0]}, 14'h0000, 14'h1388, 14'h1388, 14'h0001, 2);
      `CHK("two", i[0] ^ i[1], relay)
      `CHK("flag", !(i[0] ^ i[1]), st)
    end
    $display("two-state end");
    run(14'h1388, 14'h2710, 14'h0000, 14'h2710, 14'h0000, 14'h1388, 440, 440);
    set(0, 0, 14'h0000, 14'h2710, 14'h0000, 14'h2710, 14'h0000, 2000);
    `CHK("zero", 1'b0, relay)
    set(0, 1, 14'h0000, 14'h2710, 14'h0000, 14'h2710, 14'h0000, 2000);
    `CHK("inv", 1'b1, relay)
    set(0, 0, 14'h2710, 14'h2710, 14'h0000, 14'h2710, 14'h0000, 2000);
    `CHK("full", 1'b1, relay)
    $display("level end");
    run(14'h0000, 14'h2710, 14'h0320, 14'h2328, 14'h0001, 14'h0320, 40, 460);
    run(14'h2710, 14'h2710, 14'h0320, 14'h2328, 14'h0001, 14'h2328, 360, 40);
    run(14'h09C4, 14'h1388, 14'h0000, 14'h2710, 14'h0001, 14'h1388, 40, 40);
    dlo = 14'h07D0;
    run(14'h1F40, 14'h2710, 14'h0000, 14'h2710, 14'h0001, 14'h1D4C,
        120, 40);
    test_done;
  end
endmodule
